// [design/link_enh_pkg.sv]
// Package: offsets, fields, reset values and carriers for the link enhancement bank
package link_enh_pkg;

    // ==========================================
    // Offsets
    localparam logic [7:0]  ident_off      = 8'h2C;
    localparam logic [7:0]  enh_off        = 8'hF4;
    localparam logic [7:0]  alias_off      = 8'hF8;

    // ==========================================
    // Field layout and reset values
    localparam logic [31:0] enh_wmask      = 32'h0000_3386;
    localparam logic [31:0] enh_reset      = 32'h0000_1000;
    localparam logic [31:0] ident_reset    = 32'h0000_0000;
    localparam int          lvl_lsb        = 12;
    localparam int          music_bit      = 9;
    localparam int          video_bit      = 8;
    localparam int          prio_bit       = 7;
    localparam int          idle_bit       = 2;
    localparam int          speed_bit      = 1;
    localparam logic [1:0]  lvl_full       = 2'h0;
    localparam logic [7:0]  fmt_music      = 8'h10;
    localparam logic [7:0]  fmt_video      = 8'h00;

    typedef struct packed {
        logic        music_stamp_fix_en;
        logic        video_stamp_fix_en;
        logic        async_priority_req_en;
        logic        idle_insertion_en;
        logic        speedup_features_en;
    } feature_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage : link_enh_pkg

// [design/link_enh_regs.sv]
// Link enhancement and board identity register bank on APB
//
// The APB register port was chosen for this implementation.
module link_enh_regs
(
    input  wire logic        pclk,                 // Clock, 10 MHz
    input  wire logic        presetn,              // Async reset, active low
    input  wire logic        clk_en,               // Clock enable
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB enable
    input  wire logic        pwrite,               // APB direction
    input  wire logic [7:0]  paddr,                // APB byte address
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error
    input  wire logic        phy_feature_gate,     // PHY enhancement gate
    input  wire logic        rom_load,             // EEPROM load strobe
    input  wire logic [31:0] rom_data,             // EEPROM enhancements word
    input  wire logic        tx_underrun,          // Transmit FIFO underrun
    input  wire logic        tx_pkt_done,          // Transmit packet finished
    input  wire logic [7:0]  stream_format_code,   // Format of current stream
    output logic      [1:0]  tx_fifo_start_level,  // Threshold in use
    output logic             stamp_fix_active,     // Stamp fix for this stream
    output link_enh_pkg::feature_t features,       // Gated enable bits
    output logic      [15:0] board_device_code,    // Board device code
    output logic      [15:0] board_vendor_code     // Board vendor code
);
    typedef struct packed {
        logic [31:0]            enh;
        logic [31:0]            ident;
        logic [31:0]            rdata;
        logic                   ready;
        logic                   err;
        logic                   stamp;
        link_enh_pkg::feature_t feat;
    } bank_state_t;

    bank_state_t st_reg;
    bank_state_t st_next;
    logic        setup;
    logic        wr_acc;
    logic        hit_enh;
    logic        hit_id;
    logic [1:0]  lvl_int;
    logic [1:0]  lvl_reg;

    assign setup   = psel && !penable;
    assign hit_enh = paddr == link_enh_pkg::enh_off;
    assign hit_id  = paddr == link_enh_pkg::alias_off || paddr == link_enh_pkg::ident_off;
    assign wr_acc  = psel && penable && st_reg.ready && pwrite;

    // ==========================================
    // Register and bus logic
    always_comb
    begin
        st_next       = st_reg;
        st_next.ready = setup;
        st_next.err   = setup && !(hit_enh || hit_id);
        if (setup)
        begin
            if (pwrite || !(hit_enh || hit_id))
                st_next.rdata = 32'h0000_0000;
            else if (hit_enh)
                st_next.rdata = st_reg.enh & link_enh_pkg::enh_wmask;
            else
                st_next.rdata = st_reg.ident;
        end
        if (rom_load)
            st_next.enh = rom_data & link_enh_pkg::enh_wmask;
        if (wr_acc && hit_enh)
            st_next.enh = pwdata & link_enh_pkg::enh_wmask;
        if (wr_acc && hit_id)
            st_next.ident = pwdata;
        st_next.feat.music_stamp_fix_en    = phy_feature_gate
                                             && st_reg.enh[link_enh_pkg::music_bit];
        st_next.feat.video_stamp_fix_en    = phy_feature_gate
                                             && st_reg.enh[link_enh_pkg::video_bit];
        st_next.feat.async_priority_req_en = phy_feature_gate
                                             && st_reg.enh[link_enh_pkg::prio_bit];
        st_next.feat.idle_insertion_en     = phy_feature_gate
                                             && st_reg.enh[link_enh_pkg::idle_bit];
        st_next.feat.speedup_features_en   = phy_feature_gate
                                             && st_reg.enh[link_enh_pkg::speed_bit];
        st_next.stamp = (st_next.feat.music_stamp_fix_en
                         && stream_format_code == link_enh_pkg::fmt_music)
                     || (st_next.feat.video_stamp_fix_en
                         && stream_format_code == link_enh_pkg::fmt_video);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg       <= '0;
            st_reg.enh   <= link_enh_pkg::enh_reset;
            st_reg.ident <= link_enh_pkg::ident_reset;
        end
        else if (clk_en)
            st_reg <= st_next;
    end

    // ==========================================
    // Threshold in use
    tx_level_ctl u_lvl
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .prog_level (st_reg.enh[link_enh_pkg::lvl_lsb +: 2]),
        .underrun   (tx_underrun),
        .pkt_done   (tx_pkt_done),
        .level      (lvl_int)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_reg <= link_enh_pkg::enh_reset[13:12];
        else if (clk_en)
            lvl_reg <= lvl_int;
    end

    assign tx_fifo_start_level = lvl_reg;
    assign prdata              = st_reg.rdata;
    assign pready              = st_reg.ready;
    assign pslverr             = st_reg.err;
    assign features            = st_reg.feat;
    assign stamp_fix_active    = st_reg.stamp;
    assign board_device_code   = st_reg.ident[31:16];
    assign board_vendor_code   = st_reg.ident[15:0];

    // ==========================================
    // Checks
    sequence s_enh_write;
        psel && penable && pready && pwrite && paddr == link_enh_pkg::enh_off && clk_en;
    endsequence

    chk_rsvd_zero_read: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && paddr == link_enh_pkg::enh_off)
        |-> (prdata & ~link_enh_pkg::enh_wmask) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    chk_level_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        s_enh_write and (!rom_load) |=> st_reg.enh[13:12] == $past(pwdata[13:12]))
        else $error("threshold field not written");
    chk_gate_blocks_all: assert property (@(posedge pclk) disable iff (!presetn)
        (!phy_feature_gate && clk_en) |=> features == '0)
        else $error("features active without gate");
    chk_music_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && phy_feature_gate && st_reg.enh[9]) |=> features.music_stamp_fix_en)
        else $error("music stamp fix not enabled");
    chk_video_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && phy_feature_gate && st_reg.enh[8]) |=> features.video_stamp_fix_en)
        else $error("video stamp fix not enabled");
    chk_prio_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && phy_feature_gate && st_reg.enh[7]) |=> features.async_priority_req_en)
        else $error("priority request not enabled");
    chk_idle_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && phy_feature_gate && st_reg.enh[2]) |=> features.idle_insertion_en)
        else $error("idle insertion not enabled");
    chk_speed_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && phy_feature_gate && st_reg.enh[1]) |=> features.speedup_features_en)
        else $error("speedup not enabled");
    chk_bit6_stays_low: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.enh[6] == 1'b0)
        else $error("bit 6 became set");
    chk_alias_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_id && clk_en) |=> {board_device_code, board_vendor_code}
        == $past(pwdata))
        else $error("identity alias write lost");
    chk_ident_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_acc && hit_id) |=> $stable(st_reg.ident))
        else $error("identity changed without write");
endmodule : link_enh_regs

// [design/tx_level_ctl.sv]
// Threshold tracker: programmed start level until underrun, then full store until pkt_done ends the retry
module tx_level_ctl
(
    input  wire logic       pclk,          // Clock
    input  wire logic       presetn,       // Async reset, active low
    input  wire logic       clk_en,        // Clock enable
    input  wire logic [1:0] prog_level,    // Programmed start level
    input  wire logic       underrun,      // Transmit FIFO underran
    input  wire logic       pkt_done,      // Packet sent, retry over
    output logic      [1:0] level          // Level in use
);
    typedef struct packed {
        logic retry;
    } lvl_state_t;

    lvl_state_t st_reg;
    lvl_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (underrun)
            st_next.retry = 1'b1;
        else if (pkt_done)
            st_next.retry = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '0;
        else if (clk_en)
            st_reg <= st_next;
    end

    assign level = st_reg.retry ? link_enh_pkg::lvl_full : prog_level;

    chk_retry_full_lvl: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && underrun) |=> (level == link_enh_pkg::lvl_full))
        else $error("retry does not use full threshold");
endmodule : tx_level_ctl

// [testbench/tb.sv]
// Self-checking bench for the link enhancement and board identity register bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // Signals
    logic                   pclk, presetn, clk_en, phy_feature_gate, rom_load;
    logic                   tx_underrun, tx_pkt_done, pready, pslverr, stamp_fix_active, rerr;
    logic [7:0]             stream_format_code;
    logic [31:0]            rom_data, prdata, rdata, v;
    logic [1:0]             tx_fifo_start_level;
    logic [15:0]            board_device_code, board_vendor_code;
    link_enh_pkg::feature_t features;
    link_enh_pkg::apb_req_t req;
    int                     err_count, cmp_count, cycles;
    logic [31:0]            vals [4] = '{32'h0000_0200, 32'h0000_0200, 32'h0000_0100, 32'h0000_0186};
    logic [7:0]             fmts [4] = '{8'h10, 8'h00, 8'h00, 8'h10};
    logic                   hits [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    link_enh_regs i_dut
    (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phy_feature_gate(phy_feature_gate), .rom_load(rom_load), .rom_data(rom_data),
        .tx_underrun(tx_underrun), .tx_pkt_done(tx_pkt_done),
        .stream_format_code(stream_format_code), .tx_fifo_start_level(tx_fifo_start_level),
        .stamp_fix_active(stamp_fix_active), .features(features),
        .board_device_code(board_device_code), .board_vendor_code(board_vendor_code)
    );

    // ==========================================
    // Clock and hang guard
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    // ==========================================
    // Tasks
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge pclk);
        req.penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        req <= '0;
    endtask : apb_xfer

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic err);
        apb_xfer(1'b0, addr, 32'h0000_0000);
        chk(rdata, exp);
        chk(32'(rerr), 32'(err));
    endtask : rd_chk

    task automatic pulse(input int which);
        @(posedge pclk);
        if (which == 0)
            rom_load <= 1'b1;
        else if (which == 1)
            tx_underrun <= 1'b1;
        else
            tx_pkt_done <= 1'b1;
        @(posedge pclk);
        {rom_load, tx_underrun, tx_pkt_done} <= 3'b000;
    endtask : pulse

    // ==========================================
    // Main sequence
    initial
    begin
        {presetn, phy_feature_gate, rom_load, tx_underrun, tx_pkt_done} = '0;
        {clk_en, req, rom_data, stream_format_code} = {1'b1, 43'h0, 32'hFFFF_FFFF, 8'h10};
        {err_count, cmp_count, cycles} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(link_enh_pkg::enh_off, 32'h0000_1000, 1'b0);
        rd_chk(link_enh_pkg::alias_off, 32'h0000_0000, 1'b0);
        chk(32'(tx_fifo_start_level), 32'h0000_0001);
        apb_xfer(1'b1, link_enh_pkg::enh_off, 32'hFFFF_FFFF);
        rd_chk(link_enh_pkg::enh_off, 32'h0000_3386, 1'b0);
        rd_chk(8'h40, 32'h0000_0000, 1'b1);
        apb_xfer(1'b1, 8'h40, 32'h0000_0000);
        rd_chk(link_enh_pkg::enh_off, 32'h0000_3386, 1'b0);
        apb_xfer(1'b1, link_enh_pkg::enh_off, 32'h0000_0000);
        pulse(0);
        rd_chk(link_enh_pkg::enh_off, 32'h0000_3386, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            apb_xfer(1'b1, link_enh_pkg::enh_off, 32'(c) << 12);
            settle(3);
            chk(32'(tx_fifo_start_level), 32'(c));
        end
        // Underrun forces full store until the retried packet completes
        pulse(1);
        settle(2);
        chk(32'(tx_fifo_start_level), 32'h0000_0000);
        apb_xfer(1'b1, link_enh_pkg::enh_off, 32'h0000_2000);
        settle(3);
        chk(32'(tx_fifo_start_level), 32'h0000_0000);
        pulse(2);
        settle(3);
        chk(32'(tx_fifo_start_level), 32'h0000_0002);
        for (int i = 0; i < 8; i++)
        begin
            v = vals[i % 4];
            @(posedge pclk);
            phy_feature_gate <= (i >= 4);
            stream_format_code <= fmts[i % 4];
            apb_xfer(1'b1, link_enh_pkg::enh_off, v);
            settle(3);
            chk(32'(features), 32'({v[9], v[8], v[7], v[2], v[1]} & {5{i >= 4}}));
            chk(32'(stamp_fix_active), 32'(hits[i % 4] && i >= 4));
        end
        apb_xfer(1'b1, link_enh_pkg::alias_off, 32'hA5C3_1E69);
        rd_chk(link_enh_pkg::ident_off, 32'hA5C3_1E69, 1'b0);
        apb_xfer(1'b1, link_enh_pkg::ident_off, 32'h5A3C_E196);
        rd_chk(link_enh_pkg::alias_off, 32'h5A3C_E196, 1'b0);
        settle(1);
        chk({board_device_code, board_vendor_code}, 32'h5A3C_E196);
        rd_chk(link_enh_pkg::enh_off, 32'h0000_0186, 1'b0);
        tally_and_finish();
    end
endmodule : tb
